// File: design/cfp_regs.vh
`ifndef CFP_REGS_VH
`define CFP_REGS_VH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CFP_ADDR_W 8
`define CFP_OFF_OPTION 8'h00
`define CFP_OFF_STATUS 8'h04
`define CFP_OFF_IRQ_STATUS 8'h08
`define CFP_OFF_IRQ_CLEAR 8'h0C
`define CFP_OFF_IRQ_ENABLE 8'h10
// ****************************************************************
// charge option register fields
// ****************************************************************
`define CFP_OPT_LS_THR 7
`define CFP_OPT_HS_EN 8
`define CFP_OPT_FADJ_EN 9
`define CFP_OPT_FADJ_UP 10
`define CFP_OPT_RESET 4'h0
// ****************************************************************
// status register fields
// ****************************************************************
`define CFP_ST_THERMAL 0
`define CFP_ST_LATCHED 1
`define CFP_ST_SOFTSTART 2
`define CFP_ST_HS_CNT_LSB 4
`define CFP_ST_LS_CNT_LSB 8
// ****************************************************************
// interrupt status, clear and enable fields
// ****************************************************************
`define CFP_IRQ_W 6
`define CFP_IRQ_THERM_TRIP 0
`define CFP_IRQ_THERM_EXIT 1
`define CFP_IRQ_LATCH 2
`define CFP_IRQ_HS_SHORT 3
`define CFP_IRQ_LS_SHORT 4
`define CFP_IRQ_BOOST_CUT 5
`define CFP_IRQ_RESET 6'h00
// ****************************************************************
// counts
// ****************************************************************
`define CFP_SHORT_LIMIT 3'h7
`define CFP_BLANK_CYCLES 4
`define CFP_SS_CYCLES 256
`define CFP_RESP_OKAY 2'h0
`define CFP_RESP_SLVERR 2'h2
`endif

// File: design/cfp_short_detect.v
`timescale 1ns/1ps
`include "cfp_regs.vh"
// blanking, one-shot sampling and event count for one power transistor
module cfp_short_detect #(
  parameter BLANK_CYCLES = `CFP_BLANK_CYCLES,
  parameter BW = 8
) (
  input wire mclk,
  input wire rst,
  input wire gateOn,
  input wire overCurrent,
  input wire detectEn,
  input wire countEn,
  input wire clear,
  output reg shortEvent,
  output reg [2:0] count,
  output wire limitHit
);
  reg [BW-1:0] blankCnt;
  reg sampled;
  wire blankDone;
  wire hit;

  // comparator is only looked at once blanking has run out
  assign blankDone = (blankCnt == BLANK_CYCLES[BW-1:0]);
  // a pulse cut short before blanking ends is never sampled
  assign hit = gateOn & blankDone & ~sampled & overCurrent & detectEn;
  assign limitHit = (count == `CFP_SHORT_LIMIT);

  // blanking timer restarts at every turn-on
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      blankCnt <= {BW{1'b0}};
      sampled <= 1'b0;
    end else if (!gateOn) begin
      blankCnt <= {BW{1'b0}};
      sampled <= 1'b0;
    end else begin
      if (!blankDone)
        blankCnt <= blankCnt + {{(BW-1){1'b0}}, 1'b1};
      if (hit)
        sampled <= 1'b1;
    end
  end

  // event counter, saturating at the limit
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= 3'h0;
      shortEvent <= 1'b0;
    end else begin
      shortEvent <= hit;
      if (clear)
        count <= 3'h0;
      else if (hit && countEn && !limitHit)
        count <= count + 3'h1;
    end
  end
endmodule

// File: design/cfp_fault_ctrl.v
`timescale 1ns/1ps
`include "cfp_regs.vh"
// Overview of operation
// - stop converter when die exceeds 155 C
// - stay off until die below 135 C
// - reduced 16 mA regulator limit in shutdown
// - restart through soft start after shutdown
// - option bit 9 enables 18 percent offset
// - option bit 10 picks frequency direction
// - sample short comparators only after blanking
// - separate high-side and low-side event counters
// - count of seven latches charger off
// - latched: adapter switches off, battery switch on
// - latch clears on undervoltage or adapter-detect low
// - option bit 7 picks low-side threshold
// - option bit 8 enables high-side detection
// - boost low-side shorts only cut cycle
// - pulses ended before blanking never counted
// - soft start may need many cycles
module cfp_fault_ctrl #(
  parameter BLANK_CYCLES = `CFP_BLANK_CYCLES,
  parameter SS_CYCLES = `CFP_SS_CYCLES
) (
  input wire mclk,
  input wire rst,
  // AXI4-Lite slave
  input wire [`CFP_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`CFP_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // sensing
  input wire dieAbove155,
  input wire dieBelow135,
  input wire hsGateOn,
  input wire lsGateOn,
  input wire hsOverCur,
  input wire lsOverCur,
  input wire boostMode,
  input wire undervoltageLockout,
  input wire adapterDetectLow,
  // control
  output reg converterEnable,
  output reg softStartActive,
  output reg regulatorLimitLow,
  output reg freqAdjEn,
  output reg freqAdjUp,
  output reg lsThresholdHigh,
  output reg hsDetectEn,
  output wire lsCycleCut,
  output reg adapterInputSwitchOn,
  output reg reverseBlockSwitchOn,
  output reg batteryPathSwitchOn,
  output wire irq
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam ST_RUN = 3'b001;
  localparam ST_THERMAL = 3'b010;
  localparam ST_SOFTSTART = 3'b100;
  localparam SSW = 16;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [SSW-1:0] ssCnt;
  reg latched;
  reg [`CFP_IRQ_W-1:0] irqStatus;
  reg [`CFP_IRQ_W-1:0] irqEnable;
  reg awHeld;
  reg wHeld;
  reg [`CFP_ADDR_W-1:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  reg [31:0] readWord;
  reg readHit;
  wire doWrite;
  wire doRead;
  wire writeHit;
  wire latchClear;
  wire hsEvent;
  wire lsEvent;
  wire hsLimit;
  wire lsLimit;
  wire [2:0] hsCount;
  wire [2:0] lsCount;
  wire [`CFP_IRQ_W-1:0] irqSet;
  wire [`CFP_IRQ_W-1:0] irqClr;
  wire inThermal;
  wire ssDone;

  // ****************************************************************
  // register bus: write channel
  // ****************************************************************
  // address and data are caught separately, in either order
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign writeHit = (awAddr == `CFP_OFF_OPTION) || (awAddr == `CFP_OFF_STATUS) ||
                    (awAddr == `CFP_OFF_IRQ_STATUS) || (awAddr == `CFP_OFF_IRQ_CLEAR) ||
                    (awAddr == `CFP_OFF_IRQ_ENABLE);

  // holding registers and response
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= {`CFP_ADDR_W{1'b0}};
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[`CFP_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeHit ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // option and enable registers written by the host
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      {freqAdjUp, freqAdjEn, hsDetectEn, lsThresholdHigh} <= `CFP_OPT_RESET;
      irqEnable <= `CFP_IRQ_RESET;
    end else if (doWrite) begin
      if (awAddr == `CFP_OFF_OPTION) begin
        if (wStrb[0])
          lsThresholdHigh <= wData[`CFP_OPT_LS_THR];
        if (wStrb[1]) begin
          hsDetectEn <= wData[`CFP_OPT_HS_EN];
          freqAdjEn <= wData[`CFP_OPT_FADJ_EN];
          freqAdjUp <= wData[`CFP_OPT_FADJ_UP];
        end
      end
      if (awAddr == `CFP_OFF_IRQ_ENABLE && wStrb[0])
        irqEnable <= wData[`CFP_IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // register bus: read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign doRead = s_axi_arvalid & s_axi_arready;

  // read multiplexer; clear register and holes read as zero
  always @* begin
    readWord = 32'h00000000;
    readHit = 1'b1;
    case ({s_axi_araddr[`CFP_ADDR_W-1:2], 2'b00})
      `CFP_OFF_OPTION: begin
        readWord[`CFP_OPT_LS_THR] = lsThresholdHigh;
        readWord[`CFP_OPT_HS_EN] = hsDetectEn;
        readWord[`CFP_OPT_FADJ_EN] = freqAdjEn;
        readWord[`CFP_OPT_FADJ_UP] = freqAdjUp;
      end
      `CFP_OFF_STATUS: begin
        readWord[`CFP_ST_THERMAL] = inThermal;
        readWord[`CFP_ST_LATCHED] = latched;
        readWord[`CFP_ST_SOFTSTART] = softStartActive;
        readWord[`CFP_ST_HS_CNT_LSB+2:`CFP_ST_HS_CNT_LSB] = hsCount;
        readWord[`CFP_ST_LS_CNT_LSB+2:`CFP_ST_LS_CNT_LSB] = lsCount;
      end
      `CFP_OFF_IRQ_STATUS: readWord[`CFP_IRQ_W-1:0] = irqStatus;
      `CFP_OFF_IRQ_CLEAR: readWord = 32'h00000000;
      `CFP_OFF_IRQ_ENABLE: readWord[`CFP_IRQ_W-1:0] = irqEnable;
      default: readHit = 1'b0;
    endcase
  end

  // read data and response, held until taken
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CFP_RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= readHit ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // thermal shutdown with hysteresis and soft-start restart
  // ****************************************************************
  assign inThermal = (state == ST_THERMAL);
  assign ssDone = (ssCnt == SS_CYCLES[SSW-1:0] - {{(SSW-1){1'b0}}, 1'b1});

  // next state of the thermal sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (dieAbove155)
          next_state = ST_THERMAL;
      end
      ST_THERMAL: begin
        if (dieBelow135)
          next_state = ST_SOFTSTART;
      end
      ST_SOFTSTART: begin
        if (dieAbove155)
          next_state = ST_THERMAL;
        else if (ssDone)
          next_state = ST_RUN;
      end
      default: next_state = ST_THERMAL;
    endcase
  end

  // state register and soft-start timer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_SOFTSTART;
      ssCnt <= {SSW{1'b0}};
    end else begin
      state <= next_state;
      if (next_state == ST_SOFTSTART && state == ST_SOFTSTART)
        ssCnt <= ssCnt + {{(SSW-1){1'b0}}, 1'b1};
      else
        ssCnt <= {SSW{1'b0}};
    end
  end

  // ****************************************************************
  // short-circuit detection and latch
  // ****************************************************************
  // undervoltage or adapter removal is the only way out of the latch
  assign latchClear = undervoltageLockout | adapterDetectLow;

  // high-side path: only when enabled by option bit 8
  cfp_short_detect #(
    .BLANK_CYCLES(BLANK_CYCLES)
  ) u_hs (
    .mclk(mclk),
    .rst(rst),
    .gateOn(hsGateOn),
    .overCurrent(hsOverCur),
    .detectEn(hsDetectEn),
    .countEn(~latched),
    .clear(latchClear),
    .shortEvent(hsEvent),
    .count(hsCount),
    .limitHit(hsLimit)
  );

  // low-side path: not counted in boost
  cfp_short_detect #(
    .BLANK_CYCLES(BLANK_CYCLES)
  ) u_ls (
    .mclk(mclk),
    .rst(rst),
    .gateOn(lsGateOn),
    .overCurrent(lsOverCur),
    .detectEn(1'b1),
    .countEn(~latched & ~boostMode),
    .clear(latchClear),
    .shortEvent(lsEvent),
    .count(lsCount),
    .limitHit(lsLimit)
  );

  // in boost a low-side event only ends the present cycle
  assign lsCycleCut = lsEvent & boostMode;

  // latch: seventh event of either counter
  always @(posedge mclk or posedge rst) begin
    if (rst)
      latched <= 1'b0;
    else if (latchClear)
      latched <= 1'b0;
    else if (hsLimit || lsLimit)
      latched <= 1'b1;
  end

  // ****************************************************************
  // converter and power-path outputs
  // ****************************************************************
  // all outputs registered from the state and the latch
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      converterEnable <= 1'b0;
      softStartActive <= 1'b0;
      regulatorLimitLow <= 1'b0;
      adapterInputSwitchOn <= 1'b0;
      reverseBlockSwitchOn <= 1'b0;
      batteryPathSwitchOn <= 1'b0;
    end else begin
      converterEnable <= ~inThermal & ~latched;
      softStartActive <= (state == ST_SOFTSTART);
      regulatorLimitLow <= inThermal;
      adapterInputSwitchOn <= ~latched;
      reverseBlockSwitchOn <= ~latched;
      batteryPathSwitchOn <= latched;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irqSet[`CFP_IRQ_THERM_TRIP] = (next_state == ST_THERMAL) & ~inThermal;
  assign irqSet[`CFP_IRQ_THERM_EXIT] = inThermal & (next_state != ST_THERMAL);
  assign irqSet[`CFP_IRQ_LATCH] = ~latched & ~latchClear & (hsLimit | lsLimit);
  assign irqSet[`CFP_IRQ_HS_SHORT] = hsEvent;
  assign irqSet[`CFP_IRQ_LS_SHORT] = lsEvent & ~boostMode;
  assign irqSet[`CFP_IRQ_BOOST_CUT] = lsCycleCut;
  assign irqClr = (doWrite && awAddr == `CFP_OFF_IRQ_CLEAR && wStrb[0]) ?
                  wData[`CFP_IRQ_W-1:0] : {`CFP_IRQ_W{1'b0}};

  // sticky status, a new event wins over a clear
  always @(posedge mclk or posedge rst) begin
    if (rst)
      irqStatus <= `CFP_IRQ_RESET;
    else
      irqStatus <= (irqStatus & ~irqClr) | irqSet;
  end

  assign irq = |(irqStatus & irqEnable);
endmodule

// File: testbench/cfp_fault_ctrl_asserts.sv
`timescale 1ns/1ps
`include "cfp_regs.vh"
// ****
// port checker
// ****
module cfp_fault_ctrl_asserts #(
  parameter BLANK_CYCLES = `CFP_BLANK_CYCLES,
  parameter SS_CYCLES = `CFP_SS_CYCLES
) (
  input wire mclk,
  input wire rst,
  input wire [`CFP_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire dieAbove155,
  input wire dieBelow135,
  input wire boostMode,
  input wire undervoltageLockout,
  input wire adapterDetectLow,
  input wire converterEnable,
  input wire softStartActive,
  input wire regulatorLimitLow,
  input wire freqAdjEn,
  input wire freqAdjUp,
  input wire lsThresholdHigh,
  input wire hsDetectEn,
  input wire lsCycleCut,
  input wire adapterInputSwitchOn,
  input wire reverseBlockSwitchOn,
  input wire batteryPathSwitchOn
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // option write taken with address and data together
  sequence optWr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr[7:2] == 6'h00;
  endsequence
  // the write is applied one edge after it is taken, so pins show it two edges on
  chk_opt_upper: assert property (optWr ##0 s_axi_wstrb[1] |-> ##2
    {freqAdjUp, freqAdjEn, hsDetectEn} == $past(s_axi_wdata[10:8], 2))
    else $error("option bits 8 to 10 not applied");
  chk_opt_lower: assert property (optWr ##0 s_axi_wstrb[0] |-> ##2
    lsThresholdHigh == $past(s_axi_wdata[7], 2))
    else $error("option bit 7 not applied");
  chk_thermal_stop: assert property (dieAbove155 |-> ##2
    (!converterEnable && regulatorLimitLow))
    else $error("no shutdown after over-temperature");
  chk_limit_off: assert property (regulatorLimitLow |->
    !converterEnable && !softStartActive)
    else $error("converter active with low limit");
  chk_hyst_exit: assert property ($fell(regulatorLimitLow) |->
    softStartActive && $past(dieBelow135, 2))
    else $error("shutdown left without cool junction");
  chk_latch_isolate: assert property (batteryPathSwitchOn |->
    !adapterInputSwitchOn && !reverseBlockSwitchOn)
    else $error("adapter path on while battery path on");
  chk_latch_clear: assert property ($fell(batteryPathSwitchOn) |->
    $past(undervoltageLockout, 2) || $past(adapterDetectLow, 2))
    else $error("latch left without clear condition");
  chk_cut_pulse: assert property (lsCycleCut |->
    $past(boostMode) ##1 !lsCycleCut)
    else $error("cycle cut outside boost or too long");
endmodule

// File: testbench/cfp_host_model.sv
`timescale 1ns/1ps
// ****
// bus master standing in for the system controller
// ****
module cfp_host_model (
  input wire mclk,
  output reg [7:0] s_axi_awaddr = 8'h00,
  output reg s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h00000000,
  output reg [3:0] s_axi_wstrb = 4'h0,
  output reg s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready = 1'b0,
  output reg [7:0] s_axi_araddr = 8'h00,
  output reg s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready = 1'b0
);
  // one write; handshakes judged before the edge, released after it
  task automatic busWrite(input [7:0] a, input [31:0] d, input [3:0] s,
                          output [1:0] resp, output ok);
    integer n;
    reg aw, w;
    begin
      ok = 1'b0;
      n = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!ok && n < 200) begin
        @(negedge mclk);
        aw = s_axi_awvalid & s_axi_awready;
        w = s_axi_wvalid & s_axi_wready;
        ok = s_axi_bvalid;
        resp = s_axi_bresp;
        @(posedge mclk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
        if (w) s_axi_wdata <= ~d; // released data no longer shows the last value
        n = n + 1;
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  // one read, answer taken at the edge that sees rvalid
  task automatic busRead(input [7:0] a, output [31:0] d, output [1:0] resp, output ok);
    integer n;
    reg ar;
    begin
      ok = 1'b0;
      n = 0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!ok && n < 200) begin
        @(negedge mclk);
        ar = s_axi_arvalid & s_axi_arready;
        ok = s_axi_rvalid;
        d = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge mclk);
        if (ar) s_axi_arvalid <= 1'b0;
        n = n + 1;
      end
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// File: testbench/cfp_fault_ctrl_tb.sv
`timescale 1ns/1ps
`include "cfp_regs.vh"
// ****
// fault controller testbench
// ****
module cfp_fault_ctrl_tb;
  localparam BLANK_CYCLES = 4;
  localparam SS_CYCLES = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic dieAbove155 = 1'b0, dieBelow135 = 1'b1, boostMode = 1'b0;
  logic hsGateOn = 1'b0, lsGateOn = 1'b0, hsOverCur = 1'b0, lsOverCur = 1'b0;
  logic undervoltageLockout = 1'b0, adapterDetectLow = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic converterEnable, softStartActive, regulatorLimitLow, freqAdjEn, freqAdjUp;
  logic lsThresholdHigh, hsDetectEn, lsCycleCut, adapterInputSwitchOn;
  logic reverseBlockSwitchOn, batteryPathSwitchOn, irq, ok;
  integer errTotal = 0, cmpCount = 0, cutSeen = 0;
  // 125 MHz clock and boost cut pulse counter
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (lsCycleCut === 1'b1) cutSeen <= cutSeen + 1;
  cfp_fault_ctrl #(.BLANK_CYCLES(BLANK_CYCLES), .SS_CYCLES(SS_CYCLES)) u_cfp_fault_ctrl (.*);
  cfp_host_model u_cfp_host_model (.*);
  // ****
  // helpers
  // ****
  task automatic reportAndStop;
    begin
      $display("compares %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    begin
      cmpCount = cmpCount + 1;
      if (got !== exp) begin
        $display("mismatch %s expected %b seen %b", what, exp, got);
        errTotal = errTotal + 1;
      end
    end
  endtask
  task automatic checkWord(input string what, input [31:0] exp, input [31:0] got);
    begin
      cmpCount = cmpCount + 1;
      if (got !== exp) begin
        $display("mismatch %s expected %h seen %h", what, exp, got);
        errTotal = errTotal + 1;
      end
    end
  endtask
  // a bus wait that ran out ends the run
  task automatic busOk;
    begin
      if (ok !== 1'b1) begin
        errTotal = errTotal + 1;
        reportAndStop();
      end
    end
  endtask
  task automatic regWr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    begin
      u_cfp_host_model.busWrite(a, d, s, rsp, ok);
      busOk();
      checkWord("write resp", {30'h0, er}, {30'h0, rsp});
    end
  endtask
  task automatic regRd(input [7:0] a, input [1:0] er);
    begin
      u_cfp_host_model.busRead(a, rd, rsp, ok);
      busOk();
      checkWord("read resp", {30'h0, er}, {30'h0, rsp});
    end
  endtask
  // latch and count fields of the status word
  task automatic statusIs(input [31:0] exp);
    begin
      regRd(`CFP_OFF_STATUS, `CFP_RESP_OKAY);
      checkWord("status", exp, rd & 32'h00000772);
    end
  endtask
  task automatic switchesAre(input logic adp, input logic bat);
    begin
      @(negedge mclk);
      checkBit("adapter switch", adp, adapterInputSwitchOn);
      checkBit("reverse switch", adp, reverseBlockSwitchOn);
      checkBit("battery switch", bat, batteryPathSwitchOn);
    end
  endtask
  // gate pulse with the comparator high throughout, then a gap
  task automatic gatePulse(input logic hs, input integer len);
    begin
      repeat (len) begin
        @(posedge mclk);
        {hsGateOn, hsOverCur} <= {2{hs}};
        {lsGateOn, lsOverCur} <= {2{!hs}};
      end
      @(posedge mclk);
      {hsGateOn, hsOverCur, lsGateOn, lsOverCur} <= 4'h0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic testReset;
    begin
      // the edge that takes rst low still resets; look after the next one
      @(posedge mclk);
      @(negedge mclk);
      checkBit("soft start", 1'b1, softStartActive);
      switchesAre(1'b1, 1'b0);
      repeat (SS_CYCLES + 4) @(posedge mclk);
      @(negedge mclk);
      checkBit("soft start end", 1'b0, softStartActive);
      regRd(8'h20, `CFP_RESP_SLVERR);
      checkWord("unmapped", 32'h00000000, rd);
      regWr(8'h20, 32'hFFFFFFFF, 4'hF, `CFP_RESP_SLVERR);
      statusIs(32'h00000000);
    end
  endtask
  task automatic testOption;
    integer b;
    begin
      for (b = 7; b <= 10; b = b + 1) begin
        regWr(`CFP_OFF_OPTION, 32'h00000001 << b, 4'hF, `CFP_RESP_OKAY);
        @(negedge mclk);
        checkWord("option pins", 32'h00000001 << (b - 7),
                  {28'h0, freqAdjUp, freqAdjEn, hsDetectEn, lsThresholdHigh});
        regRd(`CFP_OFF_OPTION, `CFP_RESP_OKAY);
        checkWord("option read", 32'h00000001 << b, rd);
      end
      regWr(`CFP_OFF_OPTION, 32'h00000780, 4'h1, `CFP_RESP_OKAY);
      regRd(`CFP_OFF_OPTION, `CFP_RESP_OKAY);
      checkWord("option strobe", 32'h00000480, rd);
    end
  endtask
  task automatic testThermal;
    begin
      regWr(`CFP_OFF_IRQ_ENABLE, 32'h00000001, 4'hF, `CFP_RESP_OKAY);
      dieAbove155 <= 1'b1;
      dieBelow135 <= 1'b0;
      repeat (3) @(posedge mclk);
      dieAbove155 <= 1'b0;
      @(negedge mclk);
      checkBit("converter", 1'b0, converterEnable);
      checkBit("low limit", 1'b1, regulatorLimitLow);
      checkBit("irq trip", 1'b1, irq);
      regWr(`CFP_OFF_IRQ_ENABLE, 32'h00000000, 4'hF, `CFP_RESP_OKAY);
      checkBit("irq masked", 1'b0, irq);
      regWr(`CFP_OFF_IRQ_ENABLE, 32'h00000001, 4'hF, `CFP_RESP_OKAY);
      regWr(`CFP_OFF_IRQ_CLEAR, 32'h00000001, 4'hF, `CFP_RESP_OKAY);
      checkBit("irq cleared", 1'b0, irq);
      checkBit("still off", 1'b0, converterEnable);
      dieBelow135 <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      checkBit("restart soft", 1'b1, softStartActive);
      checkBit("limit back", 1'b0, regulatorLimitLow);
      repeat (SS_CYCLES + 4) @(posedge mclk);
      @(negedge mclk);
      checkBit("running", 1'b1, converterEnable);
      regRd(`CFP_OFF_IRQ_STATUS, `CFP_RESP_OKAY);
      checkWord("irq status", 32'h00000002, rd);
    end
  endtask
  task automatic testHighSide;
    begin
      regWr(`CFP_OFF_OPTION, 32'h00000000, 4'hF, `CFP_RESP_OKAY);
      gatePulse(1'b1, 8);
      statusIs(32'h00000000);
      regWr(`CFP_OFF_OPTION, 32'h00000100, 4'hF, `CFP_RESP_OKAY);
      gatePulse(1'b1, BLANK_CYCLES - 1);
      statusIs(32'h00000000);
      repeat (6) gatePulse(1'b1, 8);
      statusIs(32'h00000060);
      switchesAre(1'b1, 1'b0);
      gatePulse(1'b1, 8);
      switchesAre(1'b0, 1'b1);
      checkBit("latched off", 1'b0, converterEnable);
      statusIs(32'h00000072);
      adapterDetectLow <= 1'b1;
      @(posedge mclk);
      adapterDetectLow <= 1'b0;
      repeat (4) @(posedge mclk);
      switchesAre(1'b1, 1'b0);
      statusIs(32'h00000000);
    end
  endtask
  task automatic testBoost;
    begin
      boostMode <= 1'b1;
      repeat (7) gatePulse(1'b0, 8);
      checkWord("boost cuts", 32'd7, cutSeen);
      statusIs(32'h00000000);
      boostMode <= 1'b0;
      repeat (7) gatePulse(1'b0, 8);
      statusIs(32'h00000702);
      switchesAre(1'b0, 1'b1);
      undervoltageLockout <= 1'b1;
      @(posedge mclk);
      undervoltageLockout <= 1'b0;
      repeat (4) @(posedge mclk);
      switchesAre(1'b1, 1'b0);
      statusIs(32'h00000000);
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testOption();
    testThermal();
    testHighSide();
    testBoost();
    reportAndStop();
  end
endmodule
bind cfp_fault_ctrl cfp_fault_ctrl_asserts #(.BLANK_CYCLES(BLANK_CYCLES),
  .SS_CYCLES(SS_CYCLES)) u_cfp_fault_ctrl_asserts (.*);
